// [hdl/dsds_pkg.sv]
// Purpose: Constants and types of the debug serial data/status block
// Assumes: 100 MHz clk_sys, APB with 32-bit data
// Notes: Register offsets are word indices; byte address is index * 4
package dsds_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_BPS = 115200;
    localparam int OVS = 16;
    localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
    localparam logic [3:0] OVS_MID = 4'(OVS / 2 - 1);
    localparam logic [15:0] DIV_DEF = 16'(CLK_HZ / (BAUD_BPS * OVS));

    // Word indices of the registers
    localparam logic [31:0] IDX_RX_WIDE = 32'h0b0001a8;
    localparam logic [31:0] IDX_RX_NARROW = 32'h0b0001aa;
    localparam logic [31:0] IDX_TX_WIDE = 32'h0b0001ac;
    localparam logic [31:0] IDX_TX_NARROW = 32'h0b0001ae;
    localparam logic [31:0] IDX_STATUS = 32'h0b0001b0;
    localparam logic [31:0] IDX_MODE = 32'h0b0001c0;
    localparam logic [31:0] IDX_BAUD = 32'h0b0001c1;
    localparam logic [31:0] IDX_IRQ_STAT = 32'h0b0001c2;
    localparam logic [31:0] IDX_IRQ_CLR = 32'h0b0001c3;
    localparam logic [31:0] IDX_IRQ_EN = 32'h0b0001c4;

    // Status, mode and interrupt field positions, and reset values
    localparam int ST_TIP = 7;
    localparam int ST_PE = 2;
    localparam int ST_FE = 1;
    localparam int ST_OVE = 0;
    localparam int MD_NINTH = 8;
    localparam int MD_RXE = 6;
    localparam int MD_PS = 4;
    localparam int MD_CL = 3;
    localparam int MD_SL = 2;
    localparam int IRQ_TX = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_ERR = 2;
    localparam logic [8:0] TX_RST = 9'h1ff;
    localparam logic [12:0] LINE_IDLE = 13'h1fff;

    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_ZERO = 2'b01,
        PAR_ODD = 2'b10,
        PAR_EVEN = 2'b11
    } dsds_par_e;

    typedef struct packed {
        logic ninth;
        logic rx_en;
        dsds_par_e parity;
        logic char8;
        logic stop2;
    } dsds_cfg_s;

    typedef struct packed {
        logic [8:0] data;
        logic pe;
        logic fe;
    } dsds_rxres_s;

endpackage

// [hdl/dsds_rx.sv]
// Purpose: Serial frame receiver with 16x oversampling
// Assumes: tick16 is a one-cycle enable at 16 times the bit rate
// Notes: Unused data bits stay zero; only the first stop bit is checked
`timescale 1ns/100ps
`default_nettype none
module dsds_rx
    import dsds_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic tick16,
    input wire dsds_cfg_s cfg,
    input wire logic serial_rx_pin,
    output logic done,
    output dsds_rxres_s res
);

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PAR = 3'b011,
        RX_STOP = 3'b100
    } dsds_rxst_e;

    dsds_rxst_e st_r;
    logic sync1_r, sync2_r;
    logic [3:0] ovs_r;
    logic [3:0] bit_r;
    logic done_r;
    dsds_rxres_s res_r;

    // Frame shape decode
    wire logic nine_act = cfg.ninth && (cfg.parity == PAR_NONE);
    wire logic par_on = cfg.parity[1];
    wire logic [3:0] last_bit = nine_act ? 4'd8 : (cfg.char8 ? 4'd7 : 4'd6);
    wire logic smp = tick16 && (ovs_r == OVS_LAST);
    wire logic rxd = sync2_r;

    assign done = done_r;
    assign res = res_r;

    // Two-stage pin synchroniser
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= serial_rx_pin;
            sync2_r <= sync1_r;
        end
    end

    // Receive sequencer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= RX_IDLE;
            ovs_r <= 4'h0;
            bit_r <= 4'h0;
            done_r <= 1'b0;
            res_r <= '0;
        end else begin
            done_r <= 1'b0;
            if (!cfg.rx_en) begin
                st_r <= RX_IDLE;
            end else if (tick16) begin
                ovs_r <= ovs_r + 4'h1;
                unique case (st_r)
                    RX_IDLE: begin
                        ovs_r <= 4'h0;
                        if (!rxd) begin
                            st_r <= RX_START;
                        end
                    end
                    RX_START: begin
                        if (ovs_r == OVS_MID) begin
                            ovs_r <= 4'h0;
                            bit_r <= 4'h0;
                            res_r.data <= 9'h000;
                            st_r <= rxd ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (smp) begin
                            res_r.data[bit_r] <= rxd;
                            bit_r <= bit_r + 4'h1;
                            if (bit_r == last_bit) begin
                                st_r <= par_on ? RX_PAR : RX_STOP;
                                res_r.pe <= 1'b0;
                            end
                        end
                    end
                    RX_PAR: begin
                        if (smp) begin
                            res_r.pe <= (^res_r.data) ^ rxd ^ (cfg.parity == PAR_ODD);
                            st_r <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (smp) begin
                            res_r.fe <= !rxd;
                            done_r <= 1'b1;
                            st_r <= RX_IDLE;
                        end
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// [hdl/dsds_top.sv]
// Purpose: Data and status registers of a debug serial port on APB
// Assumes: APB slave with no wait states; one clock domain
// Notes: Transmit writes while busy are dropped; reads latch in setup
`timescale 1ns/100ps
`default_nettype none
module dsds_top
    import dsds_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_rx_pin,
    output logic serial_tx_pin,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    dsds_cfg_s cfg_r;
    logic [15:0] baud_r;
    logic [15:0] div_r;
    logic tick16;
    logic [8:0] rx_buf_r;
    logic rx_full_r;
    logic pe_r, fe_r, ove_r;
    logic [8:0] tx_word_r;
    logic tx_busy_r;
    logic [12:0] tx_shift_r;
    logic [3:0] tx_left_r;
    logic [3:0] tx_ovs_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_en_r;
    logic [31:0] prdata_r;
    logic rx_done;
    dsds_rxres_s rx_res;
    logic [12:0] tx_frame;
    logic [3:0] tx_len;

    ////////////////////////////////////////////////////////////////////
    // APB decode

    wire logic setup = psel && !penable;
    wire logic access = psel && penable;
    wire logic wr = access && pwrite;
    wire logic rd_setup = setup && !pwrite;

    wire logic hit_rw = paddr == (IDX_RX_WIDE << 2);
    wire logic hit_rn = paddr == (IDX_RX_NARROW << 2);
    wire logic hit_tw = paddr == (IDX_TX_WIDE << 2);
    wire logic hit_tn = paddr == (IDX_TX_NARROW << 2);
    wire logic hit_st = paddr == (IDX_STATUS << 2);
    wire logic hit_md = paddr == (IDX_MODE << 2);
    wire logic hit_bd = paddr == (IDX_BAUD << 2);
    wire logic hit_is = paddr == (IDX_IRQ_STAT << 2);
    wire logic hit_ic = paddr == (IDX_IRQ_CLR << 2);
    wire logic hit_ie = paddr == (IDX_IRQ_EN << 2);
    wire logic mapped = hit_rw || hit_rn || hit_tw || hit_tn || hit_st
        || hit_md || hit_bd || hit_is || hit_ic || hit_ie;

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = prdata_r;

    ////////////////////////////////////////////////////////////////////
    // Mode and derived frame shape

    wire logic nine_act = cfg_r.ninth && (cfg_r.parity == PAR_NONE);
    wire logic par_tx = cfg_r.parity != PAR_NONE;
    wire logic [3:0] n_bits = nine_act ? 4'd9 : (cfg_r.char8 ? 4'd8 : 4'd7);

    // Transmit write strobes, accepted only while idle
    wire logic wr_tw = wr && hit_tw;
    wire logic wr_tn = wr && hit_tn;
    wire logic tx_load = (wr_tw || wr_tn) && !tx_busy_r;
    wire logic [8:0] tx_src = wr_tw ? pwdata[8:0] : {1'b0, pwdata[7:0]};
    wire logic [7:0] tx_par_src = tx_src[7:0] & {cfg_r.char8, 7'h7f}; // Unsent bit 7 kept out

    // Receive-side events and transmit bit/frame end events
    wire logic rd_rx = rd_setup && (hit_rw || hit_rn);
    wire logic ove_ev = rx_done && rx_full_r && !rd_rx;
    wire logic err_ev = rx_done && cfg_r.rx_en && (rx_res.pe || rx_res.fe || ove_ev);
    wire logic rx_ev = rx_done && cfg_r.rx_en;
    wire logic tx_bit_end = tick16 && (tx_ovs_r == OVS_LAST);
    wire logic tx_ev = tx_busy_r && tx_bit_end && (tx_left_r == 4'h1);

    // Interrupt status with set winning over clear
    wire logic [2:0] irq_set = {err_ev, rx_ev, tx_ev};
    wire logic [2:0] irq_clr = (wr && hit_ic) ? pwdata[2:0] : 3'b000;
    wire logic [2:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

    assign irq = |(irq_stat_r & irq_en_r);

    ////////////////////////////////////////////////////////////////////
    // Read data views

    wire logic [15:0] v_rx_wide = {7'h00, rx_buf_r};
    wire logic [15:0] v_rx_narrow = {8'h00, rx_buf_r[7:0]};
    wire logic [15:0] v_tx_wide = {7'h00, tx_word_r};
    wire logic [15:0] v_tx_narrow = {8'h00, tx_word_r[7:0]};
    wire logic [15:0] v_status = {8'h00, tx_busy_r, 4'h0, pe_r, fe_r, ove_r};
    wire logic [15:0] v_mode = {7'h00, cfg_r.ninth, 1'b0, cfg_r.rx_en,
        cfg_r.parity, cfg_r.char8, cfg_r.stop2, 2'b00};

    wire logic [15:0] rd_mux =
        hit_rw ? v_rx_wide :
        hit_rn ? v_rx_narrow :
        hit_tw ? v_tx_wide :
        hit_tn ? v_tx_narrow :
        hit_st ? v_status :
        hit_md ? v_mode :
        hit_bd ? baud_r :
        hit_is ? {13'h0000, irq_stat_r} :
        hit_ie ? {13'h0000, irq_en_r} :
        16'h0000;

    ////////////////////////////////////////////////////////////////////
    // Transmit frame build: start, data, parity, stop bits, LSB first

    always_comb begin
        tx_frame = LINE_IDLE;
        tx_frame[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n_bits) begin
                tx_frame[i + 1] = tx_src[i];
            end
        end
        if (par_tx) begin
            tx_frame[n_bits + 4'h1] = (cfg_r.parity == PAR_EVEN) ? ^tx_par_src
                : (cfg_r.parity == PAR_ODD) ? ~^tx_par_src : 1'b0;
        end
        tx_len = 4'h2 + n_bits + {3'b000, par_tx} + {3'b000, cfg_r.stop2};
    end

    ////////////////////////////////////////////////////////////////////
    // Oversampling divider

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 16'h0000;
            tick16 <= 1'b0;
        end else if ({1'b0, div_r} + 17'h00001 >= {1'b0, baud_r}) begin
            div_r <= 16'h0000;
            tick16 <= 1'b1;
        end else begin
            div_r <= div_r + 16'h0001;
            tick16 <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receiver

    dsds_rx u_rx (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick16(tick16),
        .cfg(cfg_r),
        .serial_rx_pin(serial_rx_pin),
        .done(rx_done),
        .res(rx_res)
    );

    ////////////////////////////////////////////////////////////////////
    // Software-written control registers

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= '0;
            baud_r <= DIV_DEF;
            irq_en_r <= 3'b000;
        end else if (wr) begin
            if (hit_md) begin
                cfg_r.ninth <= pwdata[MD_NINTH];
                cfg_r.rx_en <= pwdata[MD_RXE];
                cfg_r.parity <= dsds_par_e'(pwdata[MD_PS +: 2]);
                cfg_r.char8 <= pwdata[MD_CL];
                cfg_r.stop2 <= pwdata[MD_SL];
            end
            if (hit_bd) begin
                baud_r <= pwdata[15:0];
            end
            if (hit_ie) begin
                irq_en_r <= pwdata[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive buffer and error status

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_buf_r <= 9'h000;
            rx_full_r <= 1'b0;
            pe_r <= 1'b0;
            fe_r <= 1'b0;
            ove_r <= 1'b0;
        end else if (rx_done) begin
            rx_buf_r <= rx_res.data;
            rx_full_r <= 1'b1;
            pe_r <= rx_res.pe;
            fe_r <= rx_res.fe;
            ove_r <= ove_ev;
        end else if (rd_rx) begin
            rx_full_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transmitter

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_word_r <= TX_RST;
            tx_busy_r <= 1'b0;
            tx_shift_r <= LINE_IDLE;
            tx_left_r <= 4'h0;
            tx_ovs_r <= 4'h0;
        end else if (tx_load) begin
            tx_word_r <= wr_tw ? pwdata[8:0] : {tx_word_r[8], pwdata[7:0]};
            tx_busy_r <= 1'b1;
            tx_shift_r <= tx_frame;
            tx_left_r <= tx_len;
            tx_ovs_r <= 4'h0;
        end else if (tx_busy_r && tick16) begin
            tx_ovs_r <= tx_ovs_r + 4'h1;
            if (tx_bit_end) begin
                tx_shift_r <= {1'b1, tx_shift_r[12:1]};
                tx_left_r <= tx_left_r - 4'h1;
                if (tx_left_r == 4'h1) begin
                    tx_busy_r <= 1'b0;
                end
            end
        end
    end

    assign serial_tx_pin = tx_shift_r[0];

    ////////////////////////////////////////////////////////////////////
    // Interrupt status and read data register

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= 3'b000;
            prdata_r <= 32'h0000_0000;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (rd_setup) begin
                prdata_r <= {16'h0000, rd_mux};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_tx_load;
        tx_load && nine_act && wr_tw;
    endsequence

    sequence s_rx_end;
        rx_done && !nine_act;
    endsequence

    property p_tx_start;
        @(posedge clk_sys) disable iff (!rst_n)
        tx_load |=> tx_busy_r && !serial_tx_pin;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("busy not set on write");

    property p_tx_end;
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(tx_busy_r) |-> irq_stat_r[IRQ_TX] && serial_tx_pin;
    endproperty
    a_tx_end: assert property (p_tx_end) else $error("done flag missing");

    property p_ninth_tx;
        @(posedge clk_sys) disable iff (!rst_n)
        s_tx_load |=> tx_shift_r[9] == $past(pwdata[8]);
    endproperty
    a_ninth_tx: assert property (p_ninth_tx) else $error("ninth bit wrong");

    property p_narrow_tx;
        @(posedge clk_sys) disable iff (!rst_n)
        tx_load && wr_tn && nine_act |=> !tx_shift_r[9];
    endproperty
    a_narrow_tx: assert property (p_narrow_tx) else $error("narrow ninth set");

    property p_overrun;
        @(posedge clk_sys) disable iff (!rst_n)
        rx_done && rx_full_r && !rd_rx |=> ove_r && rx_buf_r == $past(rx_res.data);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun lost");

    property p_rx_irq;
        @(posedge clk_sys) disable iff (!rst_n)
        rx_done && cfg_r.rx_en |=> irq_stat_r[IRQ_RX] && rx_full_r;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx done flag missing");

    property p_err_irq;
        @(posedge clk_sys) disable iff (!rst_n)
        rx_done && cfg_r.rx_en && (rx_res.pe || rx_res.fe) |=> irq_stat_r[IRQ_ERR];
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("error flag missing");

    property p_err_latest;
        @(posedge clk_sys) disable iff (!rst_n)
        rx_done |=> pe_r == $past(rx_res.pe) && fe_r == $past(rx_res.fe);
    endproperty
    a_err_latest: assert property (p_err_latest) else $error("error bits stale");

    property p_b8_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        s_rx_end |=> !rx_buf_r[8];
    endproperty
    a_b8_zero: assert property (p_b8_zero) else $error("bit 8 not zero");

    property p_b7_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        s_rx_end and !cfg_r.char8 |=> !rx_buf_r[7];
    endproperty
    a_b7_zero: assert property (p_b7_zero) else $error("bit 7 not zero");

    property p_rsv;
        @(posedge clk_sys) disable iff (!rst_n)
        rd_setup && hit_st |=> prdata_r[6:3] == 4'h0 && prdata_r[31:8] == 24'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");

    property p_line_idle;
        @(posedge clk_sys) disable iff (!rst_n)
        !tx_busy_r |-> serial_tx_pin;
    endproperty
    a_line_idle: assert property (p_line_idle) else $error("line low while idle");

    property p_narrow_rd;
        @(posedge clk_sys) disable iff (!rst_n)
        rd_setup && hit_rn |=> prdata_r == {24'h000000, $past(rx_buf_r[7:0])};
    endproperty
    a_narrow_rd: assert property (p_narrow_rd) else $error("narrow view wrong");

    property p_status_rd;
        @(posedge clk_sys) disable iff (!rst_n)
        rd_setup && hit_st |=> prdata_r[ST_TIP] == $past(tx_busy_r)
            && prdata_r[ST_PE:ST_OVE] == $past({pe_r, fe_r, ove_r});
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status view wrong");

    property p_rx_off;
        @(posedge clk_sys) disable iff (!rst_n)
        !cfg_r.rx_en |=> !rx_done;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("frame taken while off");

endmodule
`default_nettype wire

// [tb/dsds_agent.sv]
// Purpose: Serial terminal model facing the debug serial pins
// Assumes: one bit lasts BIT clk_sys cycles
// Notes: The line idles high between frames
`timescale 1ns/100ps
`default_nettype none
module dsds_agent
    import dsds_pkg::*;
#(
    parameter int BIT = 16
)
(
    input wire logic clk_sys,
    input wire logic serial_tx_pin,
    input wire logic [3:0] cap_len,
    output var logic serial_rx_pin,
    output var logic [12:0] cap_word,
    output var logic cap_valid
);
logic [12:0] w;
//////////////////////////////////////////////////
// Sends a start bit, then n frame bits LSB first, then idle
task automatic send(input logic [12:0] f, input int n, input int gap);
    serial_rx_pin <= 1'b0;
    repeat (BIT) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
        serial_rx_pin <= f[i];
        repeat (BIT) @(posedge clk_sys);
    end
    serial_rx_pin <= 1'b1;
    repeat (gap) @(posedge clk_sys);
endtask
// Captures cap_len bits after each start edge, sampled mid-bit
initial begin
    serial_rx_pin = 1'b1;
    cap_word = '0;
    cap_valid = 1'b0;
    forever begin
        @(negedge serial_tx_pin);
        repeat (BIT / 2) @(posedge clk_sys);
        w = '0;
        for (int i = 0; i < cap_len; i++) begin
            repeat (BIT) @(posedge clk_sys);
            w[i] = serial_tx_pin;
        end
        cap_word <= w;
        cap_valid <= 1'b1;
        @(posedge clk_sys);
        cap_valid <= 1'b0;
    end
end
endmodule
`default_nettype wire

// [tb/debug_serial_data_status_tb_top.sv]
// Purpose: Self-checking bench of the debug serial data and status block
// Assumes: baud divisor 1, so one bit is 16 clk_sys cycles
// Notes: Accesses and captured frames retire notes from queues
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
module debug_serial_data_status_tb_top
    import dsds_pkg::*;
;
logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, serial_rx_pin, serial_tx_pin, irq;
logic [31:0] paddr, pwdata, prdata, rd;
logic [3:0] cap_len;
logic [12:0] cap_word;
logic cap_valid;
logic [33:0] nt;
logic [33:0] note_q[$];
logic [12:0] tx_q[$];
int miscompares = 0;
int cmp_count = 0;
localparam logic [8:0] MODES [6] = '{9'h048, 9'h078, 9'h060, 9'h148, 9'h168, 9'h05c};
dsds_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin), .irq(irq));
dsds_agent #(.BIT(16)) agent_u (.clk_sys(clk_sys), .serial_tx_pin(serial_tx_pin),
    .cap_len(cap_len), .serial_rx_pin(serial_rx_pin), .cap_word(cap_word), .cap_valid(cap_valid));
//////////////////////////////////////////////////
// Clock and hang limit
initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
end
initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    end_sim();
end
// Scoreboard: each finished access or captured frame retires the oldest note
always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1) begin
        nt = note_q.pop_front();
        if (nt[33]) `CHK({pslverr, prdata}, nt[32:0])
    end
    if (cap_valid === 1'b1) begin
        nt = 34'(tx_q.pop_front());
        `CHK(cap_word, nt[12:0])
    end
end
function automatic int dn_of(input logic [8:0] m);
    return (m[8] && m[5:4] == 2'b00) ? 9 : (m[3] ? 8 : 7);
endfunction
// Frame bits after the start bit, with optional bad parity or stop
function automatic void frame(input logic [8:0] m, d, input logic tx, bp, bs,
    output logic [12:0] f, output int n);
    n = dn_of(m);
    f = 13'(d);
    if (m[5]) begin
        f[n] = (m[4] ? ^d : ~^d) ^ bp;
        n++;
    end else if (m[4] && tx) begin
        n++;
    end
    f[n] = ~bs;
    n++;
    if (m[2]) begin
        f[n] = 1'b1;
        n++;
    end
endfunction
task automatic apb(input logic w, input logic [31:0] a, d, input logic c, input logic [32:0] e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    note_q.push_back({c, e});
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a << 2, d, 1'b0, 33'h0);
endtask
task automatic rdc(input logic [31:0] a, e);
    apb(1'b0, a << 2, 32'h0, 1'b1, {1'b0, e});
endtask
task automatic rdp(input logic [31:0] a);
    apb(1'b0, a << 2, 32'h0, 1'b0, 33'h0);
endtask
task automatic tx_one(input logic [8:0] m, input logic wide);
    logic [8:0] d;
    logic [12:0] f;
    int n;
    d = 9'($urandom) & (9'h1ff >> (9 - dn_of(m))) & (wide ? 9'h1ff : 9'h0ff);
    frame(m, d, 1'b1, 1'b0, 1'b0, f, n);
    cap_len <= 4'(n);
    tx_q.push_back(f);
    wr(wide ? IDX_TX_WIDE : IDX_TX_NARROW, 32'(d));
    rdc(IDX_STATUS, 32'h80);
    rdc(wide ? IDX_TX_WIDE : IDX_TX_NARROW, 32'(d));
    do rdp(IDX_STATUS); while (rd[7] !== 1'b0);
    rdc(IDX_IRQ_STAT, 32'h1);
    `CHK(irq, 1'b1)
    wr(IDX_IRQ_EN, 32'h0);
    #1;
    `CHK(irq, 1'b0)
    wr(IDX_IRQ_EN, 32'h7);
    wr(IDX_IRQ_CLR, 32'h7);
    #1;
    `CHK(irq, 1'b0)
endtask
task automatic rx_one(input logic [8:0] m, input logic bp, bs, rd_it, ov);
    logic [8:0] d;
    logic [12:0] f;
    int n;
    d = 9'($urandom) & (9'h1ff >> (9 - dn_of(m)));
    frame(m, d, 1'b0, bp, bs, f, n);
    agent_u.send(f, n, 32);
    do rdp(IDX_IRQ_STAT); while (rd[1] !== 1'b1);
    rdc(IDX_IRQ_STAT, {29'h0, bp | bs | ov, 2'b10});
    wr(IDX_IRQ_CLR, 32'h7);
    if (rd_it) begin
        rdc(IDX_RX_WIDE, 32'(d));
        rdc(IDX_RX_NARROW, 32'(d[7:0]));
        rdc(IDX_STATUS, {29'h0, bp, bs, ov});
    end
endtask
task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
        $display("[ PASS ]");
    end else begin
        $display("[ FAIL ]");
    end
    $finish;
endtask
//////////////////////////////////////////////////
// Main sequence: reset values, each of the six MODES entries both ways, then receive errors
initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    cap_len = '0;
    void'($urandom(95351));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc(IDX_RX_WIDE, 32'h0);
    rdc(IDX_RX_NARROW, 32'h0);
    rdc(IDX_TX_WIDE, 32'h1ff);
    rdc(IDX_TX_NARROW, 32'hff);
    rdc(IDX_STATUS, 32'h0);
    wr(IDX_RX_WIDE, 32'h1ff);
    rdc(IDX_RX_WIDE, 32'h0);
    apb(1'b0, 32'h2c000640, 32'h0, 1'b1, {1'b1, 32'h0});
    wr(IDX_BAUD, 32'h1);
    wr(IDX_IRQ_EN, 32'h7);
    foreach (MODES[i]) begin
        wr(IDX_MODE, 32'(MODES[i]));
        tx_one(MODES[i], 1'b1);
        tx_one(MODES[i], 1'b0);
        rx_one(MODES[i], 1'b0, 1'b0, 1'b1, 1'b0);
    end
    wr(IDX_MODE, 32'(MODES[1]));
    rx_one(MODES[1], 1'b1, 1'b0, 1'b1, 1'b0);
    rx_one(MODES[1], 1'b0, 1'b1, 1'b1, 1'b0);
    rx_one(MODES[1], 1'b0, 1'b0, 1'b0, 1'b0);
    rx_one(MODES[1], 1'b0, 1'b0, 1'b1, 1'b1);
    rx_one(MODES[1], 1'b0, 1'b0, 1'b1, 1'b0);
    wr(IDX_MODE, 32'h8);
    agent_u.send(13'h1ff, 9, 32);
    rdc(IDX_IRQ_STAT, 32'h0);
    repeat (4) @(posedge clk_sys);
    `CHK(tx_q.size(), 0)
    `CHK(note_q.size(), 0)
    end_sim();
end
endmodule
`default_nettype wire
